//--- include/por_consts.vh
// Constants for the power-on reset sequencer and its depop timer
`ifndef POR_CONSTS_VH
`define POR_CONSTS_VH

// System clock period in nanoseconds (25 MHz)
`define CLK_PERIOD_NS        40
// Typical reset extension after both supplies are good, in nanoseconds
`define POR_EXT_TIME_NS      50000
// Longest permitted reset extension, in nanoseconds
`define POR_EXT_MAX_NS       100000
// Extension in clock cycles, the typical figure rounded down
`define POR_EXT_CYCLES       (`POR_EXT_TIME_NS / `CLK_PERIOD_NS)
// Ceiling of the extension in clock cycles, rounded down
`define POR_EXT_MAX_CYCLES   (`POR_EXT_MAX_NS / `CLK_PERIOD_NS)
// Depop delay base, in master clock ticks at the lowest rate setting
`define DEPOP_BASE_TICKS     16'h0100
// Width of the sample-rate setting
`define RATE_SEL_W           3
// Largest shift applied to the depop base for the highest rate setting
`define RATE_SHIFT_MAX       5

`endif

//--- hdl/depop_timer.v
// Depop delay timer clocked by master clock ticks, scaled by sample rate
`timescale 1ns/100ps
`include "por_consts.vh"

module depop_timer #(
    parameter             CNT_W  = 24,
    parameter [15:0]      BASE   = `DEPOP_BASE_TICKS
) (
    input  wire                   clk_in,
    input  wire                   reset_in,
    input  wire                   clear_in,
    input  wire                   mclk_tick_in,
    input  wire [`RATE_SEL_W-1:0] rate_sel_in,
    input  wire                   enable_in,
    output reg                    busy_out,
    output reg                    done_out
);

    // Higher sample rates scale the delay by powers of two
    function [2:0] rate_shift;
        input [`RATE_SEL_W-1:0] sel;
        begin
            if (sel > `RATE_SHIFT_MAX) begin
                rate_shift = 3'd`RATE_SHIFT_MAX;
            end else begin
                rate_shift = sel[2:0];
            end
        end
    endfunction

    reg             enable_q;
    reg [CNT_W-1:0] tick_cnt_q;
    reg [CNT_W-1:0] target_q;
    wire            start;
    wire [CNT_W-1:0] target_d;

    assign start    = enable_in & ~enable_q;
    assign target_d = {{(CNT_W-16){1'b0}}, BASE} << rate_shift(rate_sel_in); // R7

    // Count master clock ticks from the output enable edge; reset or disable aborts
    always @(posedge clk_in) begin
        if (reset_in || clear_in) begin
            enable_q   <= 1'b0;
            tick_cnt_q <= {CNT_W{1'b0}};
            target_q   <= {CNT_W{1'b0}};
            busy_out   <= 1'b0;
            done_out   <= 1'b0;
        end else begin
            enable_q <= enable_in;
            done_out <= 1'b0;
            if (!enable_in) begin
                busy_out   <= 1'b0;
                tick_cnt_q <= {CNT_W{1'b0}};
            end else if (start) begin
                busy_out   <= 1'b1;
                tick_cnt_q <= {CNT_W{1'b0}};
                target_q   <= target_d; // R7
            end else if (busy_out && mclk_tick_in) begin
                if (tick_cnt_q == target_q - 1'b1) begin
                    busy_out <= 1'b0; // R7
                    done_out <= 1'b1;
                end
                tick_cnt_q <= tick_cnt_q + 1'b1;
            end
        end
    end

endmodule // depop_timer

//--- hdl/power_on_reset_sequencer.v
// Internal power-on reset sequencer with control-port gating and depop timing
// Operation
// R1: Reset is internal only; asserted while either supply-good indication is low.
// R2: During reset every register and control is forced to its initial value.
// R3: Control-port accesses during reset are discarded; no write or action takes effect.
// R4: After both supplies good, reset extends about 50 us, never over 100 us.
// R5: Any supply drop re-enters reset; a fresh extension starts when both return.
// R6: Host sends no audio until 250 ms after outputs enabled and clock running.
// R7: Depop delays count master clock ticks scaled by the sample-rate setting.
// R8: Supply-good inputs are synchronised; extension count restarts on every good edge.
`timescale 1ns/100ps
`include "por_consts.vh"

module power_on_reset_sequencer #(
    parameter EXT_W  = 12,
    parameter ADDR_W = 7,
    parameter DATA_W = 9,
    parameter CNT_W  = 24
) (
    input  wire                   clk_in,
    input  wire                   reset_in,
    input  wire                   analog_supply_good_in,
    input  wire                   core_supply_good_in,
    input  wire                   ctrl_wr_in,
    input  wire                   ctrl_rd_in,
    input  wire [ADDR_W-1:0]      ctrl_addr_in,
    input  wire [DATA_W-1:0]      ctrl_wdata_in,
    input  wire                   mclk_tick_in,
    input  wire [`RATE_SEL_W-1:0] rate_sel_in,
    input  wire                   output_enable_in,
    output reg                    por_active_out,
    output reg                    regs_init_out,
    output reg                    ctrl_wr_out,
    output reg                    ctrl_rd_out,
    output reg  [ADDR_W-1:0]      ctrl_addr_out,
    output reg  [DATA_W-1:0]      ctrl_wdata_out,
    output reg                    ctrl_dropped_out,
    output reg                    por_seen_out,
    output wire                   depop_busy_out,
    output wire                   depop_done_out
);

    // One-hot sequencer states
    localparam [2:0] ST_HOLD   = 3'b001;
    localparam [2:0] ST_EXTEND = 3'b010;
    localparam [2:0] ST_RUN    = 3'b100;

    // Cycle counts kept at full width first, so the narrowing below is deliberate
    localparam [31:0] EXT_LAST_I = `POR_EXT_CYCLES - 1;
    localparam [31:0] EXT_CEIL_I = `POR_EXT_MAX_CYCLES - 1;

    // Last extension count; the typical figure sits well inside the ceiling.
    // EXT_W must hold the ceiling count, or the guard compare would alias.
    localparam [EXT_W-1:0] EXT_LAST = EXT_LAST_I[EXT_W-1:0];
    localparam [EXT_W-1:0] EXT_CEIL = EXT_CEIL_I[EXT_W-1:0];

    // Reset is held in every state but RUN; one decode feeds both reset outputs
    function held_in_reset;
        input [2:0] st;
        begin
            held_in_reset = (st != ST_RUN);
        end
    endfunction

    reg  [1:0]       sync1_q;
    reg  [1:0]       sync2_q;
    reg              both_good_q;
    wire [1:0]       supply_raw;
    wire             both_good;
    wire             good_rise;

    // Sequencer state and extension counter
    reg  [2:0]       state_q;
    reg  [2:0]       state_d;
    reg  [EXT_W-1:0] ext_cnt_q;
    reg  [EXT_W-1:0] ext_cnt_d;
    wire             ext_done;

    // Bit 0 carries the analog indication, bit 1 the core one
    assign supply_raw = {core_supply_good_in, analog_supply_good_in};

    // Two-stage synchroniser per supply indication; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_sync
            always @(posedge clk_in) begin
                if (reset_in) begin
                    sync1_q[i] <= 1'b0; // R8
                    sync2_q[i] <= 1'b0;
                end else begin
                    sync1_q[i] <= supply_raw[i]; // R8
                    sync2_q[i] <= sync1_q[i];
                end
            end
        end
    endgenerate

    // Combined good condition and its rising edge, from synchronised copies only
    assign both_good = &sync2_q; // R1
    assign good_rise = both_good & ~both_good_q; // R8

    // Delayed copy for the edge detector; it resets low, matching the synchronisers,
    // so the first good condition after reset is always seen as a rise
    always @(posedge clk_in) begin
        if (reset_in) begin
            both_good_q <= 1'b0;
        end else begin
            both_good_q <= both_good;
        end
    end

    // Extension ends at the typical count; the ceiling guards a misset count
    // With the default counts the ceiling compare is never reached
    assign ext_done = (ext_cnt_q == EXT_LAST) || (ext_cnt_q == EXT_CEIL); // R4

    // Sequencer: a supply drop wins over everything so no stale release survives
    // Limitation: a dip shorter than one clock period can slip between samples
    always @* begin
        state_d   = state_q;
        ext_cnt_d = ext_cnt_q;
        case (state_q)
            ST_HOLD: begin
                ext_cnt_d = {EXT_W{1'b0}};
                if (both_good) begin
                    state_d = ST_EXTEND; // R4
                end
            end
            ST_EXTEND: begin
                if (!both_good) begin
                    state_d   = ST_HOLD; // R5
                    ext_cnt_d = {EXT_W{1'b0}};
                end else if (ext_done) begin
                    state_d = ST_RUN; // R4
                end else begin
                    ext_cnt_d = ext_cnt_q + 1'b1;
                end
            end
            ST_RUN: begin
                if (!both_good) begin
                    state_d   = ST_HOLD; // R5
                    ext_cnt_d = {EXT_W{1'b0}};
                end
            end
            default: begin
                state_d   = ST_HOLD;
                ext_cnt_d = {EXT_W{1'b0}};
            end
        endcase
        if (good_rise) begin
            ext_cnt_d = {EXT_W{1'b0}}; // R8
        end
    end

    // State and extension counter registers
    always @(posedge clk_in) begin
        if (reset_in) begin
            state_q   <= ST_HOLD;
            ext_cnt_q <= {EXT_W{1'b0}};
        end else begin
            state_q   <= state_d;
            ext_cnt_q <= ext_cnt_d;
        end
    end

    // Reset level and register-initialise level follow the next state, one flop deep
    always @(posedge clk_in) begin
        if (reset_in) begin
            por_active_out <= 1'b1;
            regs_init_out  <= 1'b1;
        end else begin
            por_active_out <= held_in_reset(state_d); // R1
            regs_init_out  <= held_in_reset(state_d); // R2
        end
    end

    // Control port gate: accesses are passed on only outside reset
    // Address and data are zeroed rather than held, so nothing stale leaks out later.
    // The host can learn that reset ended from ctrl_dropped_out staying low on an access, without a write and read-back.
    always @(posedge clk_in) begin
        if (reset_in || por_active_out) begin
            ctrl_wr_out      <= 1'b0; // R3
            ctrl_rd_out      <= 1'b0; // R3
            ctrl_addr_out    <= {ADDR_W{1'b0}}; // R2
            ctrl_wdata_out   <= {DATA_W{1'b0}}; // R2
            ctrl_dropped_out <= ~reset_in & (ctrl_wr_in | ctrl_rd_in); // R3
        end else begin
            ctrl_wr_out      <= ctrl_wr_in;
            ctrl_rd_out      <= ctrl_rd_in;
            ctrl_dropped_out <= 1'b0;
            if (ctrl_wr_in || ctrl_rd_in) begin
                ctrl_addr_out  <= ctrl_addr_in;
                ctrl_wdata_out <= ctrl_wdata_in;
            end
        end
    end

    // Sticky record of a supply-triggered reset; lets a status path see past events.
    // Cleared only by the external reset, so a later drop cannot be missed.
    always @(posedge clk_in) begin
        if (reset_in) begin
            por_seen_out <= 1'b0;
        end else if (state_q != ST_HOLD && !both_good) begin
            por_seen_out <= 1'b1; // R5
        end
    end

    // Depop delays run from the master clock and are cleared by the power-on reset.
    // The host must still hold off audio well beyond these delays after enabling.
    // Ticks arriving while no delay runs are ignored inside the timer.
    depop_timer #(
        .CNT_W (CNT_W),
        .BASE  (`DEPOP_BASE_TICKS)
    ) u_depop (
        .clk_in       (clk_in),
        .reset_in     (reset_in),
        .clear_in     (por_active_out),
        .mclk_tick_in (mclk_tick_in),
        .rate_sel_in  (rate_sel_in),
        .enable_in    (output_enable_in),
        .busy_out     (depop_busy_out),
        .done_out     (depop_done_out)
    ); // R7

endmodule // power_on_reset_sequencer

//--- dv/supply_model.sv
// Behavioural supply monitors; slow mode lags each change by 20 cycles
`timescale 1ns/100ps
module supply_model (
    input  wire       clk_in,
    input  wire [1:0] want_in,
    input  wire       slow_in,
    output reg        analog_supply_good_out = 1'b0,
    output reg        core_supply_good_out = 1'b0
);
    integer lag_q = 0;
    // Level follows the request once the lag has run out
    always @(posedge clk_in) begin
        lag_q <= (want_in == {analog_supply_good_out, core_supply_good_out}) ? 0 : lag_q + 1;
        if (lag_q >= (slow_in ? 20 : 0))
            {analog_supply_good_out, core_supply_good_out} <= want_in;
    end
endmodule // supply_model

//--- dv/por_checker_properties.sv
// Port-level checker for the power-on reset sequencer
`timescale 1ns/100ps
module por_checker #(
    parameter ADDR_W = 7,
    parameter DATA_W = 9
) (
    input wire              clk_in,
    input wire              reset_in,
    input wire              analog_supply_good_in,
    input wire              core_supply_good_in,
    input wire              ctrl_wr_in,
    input wire              ctrl_rd_in,
    input wire [ADDR_W-1:0] ctrl_addr_in,
    input wire [DATA_W-1:0] ctrl_wdata_in,
    input wire              por_active_out,
    input wire              regs_init_out,
    input wire              ctrl_wr_out,
    input wire              ctrl_rd_out,
    input wire [ADDR_W-1:0] ctrl_addr_out,
    input wire [DATA_W-1:0] ctrl_wdata_out,
    input wire              ctrl_dropped_out,
    input wire              por_seen_out,
    input wire              depop_busy_out,
    input wire              depop_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // Edges with both supplies good; saturates so a long run never wraps
    reg [11:0] good_q;
    always @(posedge clk_in)
        good_q <= (reset_in || !(analog_supply_good_in && core_supply_good_in)) ? 12'h0 :
                  (&good_q) ? good_q : good_q + 12'h001;
    drop_reenters_a: assert property (
        !(analog_supply_good_in && core_supply_good_in) |-> ##[3:4] por_active_out)
        else $error("supply drop left reset released");
    init_follows_a: assert property (regs_init_out == por_active_out)
        else $error("init and reset disagree");
    fields_cleared_a: assert property (
        por_active_out && $past(por_active_out) |-> ~|{ctrl_addr_out, ctrl_wdata_out})
        else $error("fields not cleared in reset");
    access_refused_a: assert property (
        (ctrl_wr_in || ctrl_rd_in) && por_active_out |=>
        ctrl_dropped_out && !ctrl_wr_out && !ctrl_rd_out) else $error("access leaked");
    write_passed_a: assert property (ctrl_wr_in && !por_active_out |=> ctrl_wr_out &&
        !ctrl_dropped_out && ctrl_addr_out == $past(ctrl_addr_in) &&
        ctrl_wdata_out == $past(ctrl_wdata_in)) else $error("write lost");
    read_passed_a: assert property (ctrl_rd_in && !por_active_out |=> ctrl_rd_out)
        else $error("read lost");
    ext_min_a: assert property ($fell(por_active_out) |-> good_q >= 12'h4e0)
        else $error("extension too short");
    ext_max_a: assert property (good_q >= 12'h4ec |-> !por_active_out)
        else $error("extension too long");
    seen_sticky_a: assert property (por_seen_out |=> por_seen_out)
        else $error("drop record lost");
    done_pulse_a: assert property (
        depop_done_out |-> $past(depop_busy_out) ##1 !depop_done_out)
        else $error("depop done malformed");
    cover property ($fell(por_active_out));
    cover property (ctrl_dropped_out);
    cover property (depop_done_out);
endmodule // por_checker
bind power_on_reset_sequencer por_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .clk_in, .reset_in, .analog_supply_good_in, .core_supply_good_in, .ctrl_wr_in,
    .ctrl_rd_in, .por_active_out, .regs_init_out, .ctrl_wr_out, .ctrl_rd_out,
    .ctrl_dropped_out, .por_seen_out, .depop_busy_out, .depop_done_out, .ctrl_addr_in,
    .ctrl_addr_out, .ctrl_wdata_in, .ctrl_wdata_out);

//--- dv/testbench.sv
// Self-checking bench for the power-on reset sequencer
`timescale 1ns/100ps
`define CHK(c, m) begin n_checks++; if ((c) !== 1'b1) begin fails++; \
    $display("unexpected %0t %s", $time, m); end end
module testbench;
    reg        clk_in, reset_in, ctrl_wr_in, ctrl_rd_in, mclk_tick_in, output_enable_in, slow;
    reg  [6:0] ctrl_addr_in;
    reg  [8:0] ctrl_wdata_in;
    reg  [2:0] rate_sel_in;
    reg  [1:0] want;
    reg  [7:0] lfsr_q;
    wire       analog_supply_good_in, core_supply_good_in, por_active_out, regs_init_out;
    wire       ctrl_wr_out, ctrl_rd_out, ctrl_dropped_out, por_seen_out;
    wire       depop_busy_out, depop_done_out;
    wire [6:0] ctrl_addr_out;
    wire [8:0] ctrl_wdata_out;
    integer    fails = 0, n_checks = 0, exp_por, i, n, cnt;
    power_on_reset_sequencer i_dut (.clk_in, .reset_in, .analog_supply_good_in,
        .core_supply_good_in, .ctrl_wr_in, .ctrl_rd_in, .ctrl_addr_in, .ctrl_wdata_in,
        .mclk_tick_in, .rate_sel_in, .output_enable_in, .por_active_out, .regs_init_out,
        .ctrl_wr_out, .ctrl_rd_out, .ctrl_addr_out, .ctrl_wdata_out, .ctrl_dropped_out,
        .por_seen_out, .depop_busy_out, .depop_done_out);
    supply_model i_sup (.clk_in, .want_in(want), .slow_in(slow),
        .analog_supply_good_out(analog_supply_good_in),
        .core_supply_good_out(core_supply_good_in));
    function [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Inputs always move 1 ns after the edge, clear of sampling
    task step(input integer k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    // Ask the monitors for a level and wait, bounded, until they show it
    task supply(input [1:0] v, input s);
        want = v;
        slow = s;
        cnt = 0;
        while ({analog_supply_good_in, core_supply_good_in} !== v && cnt < 100) begin
            step(1);
            cnt++;
        end
        `CHK({analog_supply_good_in, core_supply_good_in} === v, "supply stuck")
    endtask
    // One random control access, judged against the modelled reset level
    task access(input w);
        lfsr_q = lfsr(lfsr_q);
        ctrl_wr_in = w;
        ctrl_rd_in = !w;
        ctrl_addr_in = lfsr_q[6:0];
        ctrl_wdata_in = {lfsr_q, w};
        step(1);
        `CHK(por_active_out === exp_por[0] && regs_init_out === exp_por[0], "level")
        `CHK(ctrl_dropped_out === exp_por[0], "drop flag")
        `CHK(ctrl_wr_out === (w & !exp_por[0]) && ctrl_rd_out === (!w & !exp_por[0]), "strobe")
        `CHK(exp_por || (ctrl_addr_out === ctrl_addr_in && ctrl_wdata_out === ctrl_wdata_in), "data")
        `CHK(!exp_por || ctrl_addr_out === 7'h0, "not cleared")
        ctrl_wr_in = 0;
        ctrl_rd_in = 0;
        step(1);
    endtask
    task report_and_stop;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        clk_in = 0;
        forever #20 clk_in = ~clk_in;
    end
    // Watchdog well beyond the longest depop runs plus two extensions
    initial begin
        repeat (60000) @(posedge clk_in);
        fails++;
        report_and_stop;
    end
    initial begin
        {reset_in, ctrl_wr_in, ctrl_rd_in, mclk_tick_in, output_enable_in, slow} = 6'h20;
        {ctrl_addr_in, ctrl_wdata_in, rate_sel_in, want} = 21'h0;
        lfsr_q = 8'h14;
        exp_por = 1;
        step(6);
        reset_in = 0;
        // Supplies low: accesses are swallowed
        step(4);
        access(1);
        access(0);
        // Extension still running at 1200 cycles, over by 1264
        supply(2'h3, 0);
        step(1200);
        access(1);
        step(60);
        exp_por = 0;
        access(1);
        access(0);
        `CHK(por_seen_out === 1'b0, "early drop record")
        // Core drop brings reset back and is remembered
        supply(2'h2, 0);
        step(6);
        exp_por = 1;
        `CHK(por_seen_out === 1'b1, "drop unseen")
        access(0);
        // Short analog dip mid-extension must restart the count from zero
        supply(2'h3, 1);
        step(600);
        supply(2'h1, 0);
        step(2);
        supply(2'h3, 0);
        step(1200);
        access(1);
        step(60);
        exp_por = 0;
        access(1);
        // Depop delay scales with the rate setting, capped at shift 5
        for (i = 0; i < 3; i++) begin
            lfsr_q = lfsr(lfsr_q);
            rate_sel_in = lfsr_q[2:0];
            n = 256 << ((lfsr_q[2:0] > 5) ? 5 : lfsr_q[2:0]);
            // No serial audio is ever driven, so the host hold-off after enabling is kept
            output_enable_in = 1;
            cnt = 0;
            // Ticks come every other cycle, so a timer counting cycles would end early
            while (depop_done_out !== 1'b1 && cnt < 17000) begin
                mclk_tick_in = cnt[0];
                step(1);
                cnt++;
                if (cnt == 2) `CHK(depop_busy_out === 1'b1, "depop idle")
            end
            `CHK(cnt >= 2 * n && cnt <= 2 * n + 4, "depop length")
            `CHK(depop_busy_out === 1'b0, "depop still busy")
            output_enable_in = 0;
            mclk_tick_in = 0;
            step(2);
        end
        report_and_stop;
    end
endmodule // testbench
